// *** pkg/cmt_map.svh ***
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH
// register addresses
`define CMT_ADDR_POWER_CONTROL_REGISTER   8'h05
`define CMT_ADDR_CELL5_TRIM  8'h15
`define CMT_ADDR_CELL6_TRIM  8'h16
`define CMT_ADDR_MSB_LOW     8'h17
`define CMT_ADDR_MSB_HIGH    8'h18
`define CMT_ADDR_REF_MSB     8'h1B
// power control fields
`define CMT_PWR_SLEEP_BIT    7
`define CMT_PWR_INHIBIT_BIT  6
`define CMT_PWR_RESET        8'h00
// unmapped reads
`define CMT_READ_DEFAULT     8'h00
`endif

// *** pkg/cmt_pkg.sv ***
`default_nettype none
package cmt_pkg;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmt_req_t;

    typedef enum logic [1:0] {
        CMT_ACTIVE   = 2'b00,
        CMT_DRAIN    = 2'b01,
        CMT_ARMED    = 2'b10
    } cmt_state_t;

    // nonvolatile trim image: cell 5 and 6 low nibbles, top bits of cells 1 to 6, reference bits
    typedef struct packed {
        logic [3:0] c5_off_low;
        logic [3:0] c5_gain_low;
        logic [3:0] c6_off_low;
        logic [3:0] c6_gain_low;
        logic [5:0] off_top;
        logic [5:0] gain_top;
        logic       ref_off_b5;
        logic       ref_off_b4;
        logic       ref_gain_top;
    } cmt_trim_t;
endpackage
`default_nettype wire

// *** logic/cmt_trim_sleep.sv ***
// Summary of operation
// R1 - cell 5 trim upper nibble holds low four offset bits
// R2 - cell 5 trim lower nibble holds low four gain bits
// R3 - cell 6 trim upper nibble holds low four offset bits
// R4 - cell 6 trim lower nibble holds low four gain bits
// R5 - first extension: cell 1 offset, gain, cell 2 offset, gain in bits 7..4
// R6 - second extension: offset then gain top bits of cells 3 to 6
// R7 - reference extension: offset bit5, offset bit4, gain top in bits 2..0
// R8 - host builds 6-bit signed reference offset from extension and low bits
// R9 - writing the sleep bit puts the device into shutdown
// R10 - wake stays disarmed until the regulator output reaches 0 V
// R11 - once armed, wake pin high brings the device out of shutdown
// R12 - sleep entered by writing one to bit 7 of power control
// R13 - sleep inhibit set makes the device ignore sleep requests
// R14 - trim registers read-only, return programmed contents, ignore writes
`include "cmt_map.svh"
`default_nettype none
module cmt_trim_sleep (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // register port
    input  wire cmt_pkg::cmt_req_t req,
    input  wire logic              req_valid,
    output logic [7:0]             rdata,
    // nonvolatile trim image
    input  wire cmt_pkg::cmt_trim_t trim,
    // analog status pins
    input  wire logic              regulator_zero,
    input  wire logic              wake_pin,
    // power state
    output logic                   shutdown,
    output logic                   wake_armed,
    output logic [7:0]             power_control
);
    import cmt_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic [2:0] zero_sync_q;
    logic [2:0] wake_sync_q;
    logic       zero_q;
    logic       wake_q;
    logic [7:0] power_control_q;
    cmt_state_t state_q;
    logic       sleep_req;

    // one decode shared by the power control write logic and the checks
    function automatic logic port_hit(input cmt_req_t r, input logic valid, input logic wr,
                                      input logic [7:0] addr);
        return valid && (r.wr == wr) && (r.addr == addr);
    endfunction

    // pins: three stages, accept a change once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_sync_q <= 3'h0;
            wake_sync_q <= 3'h0;
        end else begin
            zero_sync_q <= {zero_sync_q[1:0], regulator_zero};
            wake_sync_q <= {wake_sync_q[1:0], wake_pin};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (zero_sync_q[2] == zero_sync_q[1])
                zero_q <= zero_sync_q[2];
            if (wake_sync_q[2] == wake_sync_q[1])
                wake_q <= wake_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////
    // power control register; sleep bit self-clears on wake
    assign sleep_req = port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER)
                       && req.wdata[`CMT_PWR_SLEEP_BIT]
                       && !req.wdata[`CMT_PWR_INHIBIT_BIT]
                       && !power_control_q[`CMT_PWR_INHIBIT_BIT];  // R13

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_control_q <= `CMT_PWR_RESET;
        // a write in the wake cycle wins; the host rewrites the register after wake
        end else if (port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER)) begin
            power_control_q <= req.wdata;
            if (!sleep_req)
                power_control_q[`CMT_PWR_SLEEP_BIT] <= 1'b0;  // R13
        end else if (state_q == CMT_ARMED && wake_q) begin
            power_control_q[`CMT_PWR_SLEEP_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // shutdown sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= CMT_ACTIVE;
        end else begin
            unique case (state_q)
                CMT_ACTIVE: begin
                    if (sleep_req)
                        state_q <= CMT_DRAIN;  // R9 R12
                end
                CMT_DRAIN: begin
                    // regulator must be fully discharged before arming
                    if (zero_q)
                        state_q <= CMT_ARMED;  // R10
                end
                CMT_ARMED: begin
                    if (wake_q)
                        state_q <= CMT_ACTIVE;  // R11
                end
                default: state_q <= CMT_ACTIVE;
            endcase
        end
    end

    assign shutdown      = (state_q != CMT_ACTIVE);
    assign wake_armed    = (state_q == CMT_ARMED);
    assign power_control = power_control_q;

    ////////////////////////////////////////////////////////////////
    // read mux; trim addresses have no write path at all
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= `CMT_READ_DEFAULT;
        end else if (req_valid && !req.wr) begin
            case (req.addr)
                `CMT_ADDR_POWER_CONTROL_REGISTER:  rdata <= power_control_q;
                `CMT_ADDR_CELL5_TRIM: rdata <= {trim.c5_off_low, trim.c5_gain_low};  // R1 R2 R14
                `CMT_ADDR_CELL6_TRIM: rdata <= {trim.c6_off_low, trim.c6_gain_low};  // R3 R4 R14
                `CMT_ADDR_MSB_LOW:    rdata <= {trim.off_top[0], trim.gain_top[0],
                                                trim.off_top[1], trim.gain_top[1], 4'h0};  // R5
                `CMT_ADDR_MSB_HIGH:   rdata <= {trim.off_top[2], trim.gain_top[2],
                                                trim.off_top[3], trim.gain_top[3],
                                                trim.off_top[4], trim.gain_top[4],
                                                trim.off_top[5], trim.gain_top[5]};  // R6
                // upper reference offset bits feed the host's 6-bit value
                `CMT_ADDR_REF_MSB:    rdata <= {5'h00, trim.ref_off_b5,
                                                trim.ref_off_b4, trim.ref_gain_top};  // R7 R8
                default:              rdata <= `CMT_READ_DEFAULT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // sleep sequence checks
    sleep_enter_a: assert property (@(posedge clk_sys) disable iff (rst)  // R9
        (state_q == CMT_ACTIVE && sleep_req) |=> state_q == CMT_DRAIN)
        else $error("sleep write did not start shutdown");
    bit_seven_a: assert property (@(posedge clk_sys) disable iff (rst)  // R12
        (state_q == CMT_ACTIVE && port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER)
            && req.wdata[`CMT_PWR_SLEEP_BIT] && !req.wdata[`CMT_PWR_INHIBIT_BIT]
            && !power_control_q[`CMT_PWR_INHIBIT_BIT])
        |=> shutdown && power_control_q[`CMT_PWR_SLEEP_BIT])
        else $error("sleep bit write ignored");
    bit_clear_a: assert property (@(posedge clk_sys) disable iff (rst)  // R12
        (state_q == CMT_ACTIVE && port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER)
            && !req.wdata[`CMT_PWR_SLEEP_BIT])
        |=> !shutdown && !power_control_q[`CMT_PWR_SLEEP_BIT])
        else $error("slept without sleep bit");
    inhibit_hold_a: assert property (@(posedge clk_sys) disable iff (rst)  // R13
        (state_q == CMT_ACTIVE && power_control_q[`CMT_PWR_INHIBIT_BIT]) |=> state_q == CMT_ACTIVE)
        else $error("slept while inhibited");
    inhibit_same_a: assert property (@(posedge clk_sys) disable iff (rst)  // R13
        (state_q == CMT_ACTIVE && port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER)
            && req.wdata[`CMT_PWR_INHIBIT_BIT]) |=> !shutdown)
        else $error("slept on inhibited write");
    drain_wait_a: assert property (@(posedge clk_sys) disable iff (rst)  // R10
        (state_q == CMT_DRAIN && !zero_q) |=> state_q == CMT_DRAIN)
        else $error("armed before discharge");
    no_early_wake_a: assert property (@(posedge clk_sys) disable iff (rst)  // R10
        ($past(state_q) == CMT_DRAIN) |-> state_q != CMT_ACTIVE)
        else $error("woke before arming");
    zero_agree_a: assert property (@(posedge clk_sys) disable iff (rst)  // R10
        (zero_sync_q[2] != zero_sync_q[1]) |=> $stable(zero_q))
        else $error("discharge level taken before stages agree");
    armed_hold_a: assert property (@(posedge clk_sys) disable iff (rst)  // R11
        (state_q == CMT_ARMED && !wake_q) |=> wake_armed && shutdown)
        else $error("left armed state without wake");
    armed_wake_a: assert property (@(posedge clk_sys) disable iff (rst)  // R11
        (state_q == CMT_ARMED && wake_q) |=> !shutdown)
        else $error("wake pin ignored");
    wake_clear_a: assert property (@(posedge clk_sys) disable iff (rst)  // R11
        (state_q == CMT_ARMED && wake_q && !port_hit(req, req_valid, 1'b1, `CMT_ADDR_POWER_CONTROL_REGISTER))
        |=> !power_control_q[`CMT_PWR_SLEEP_BIT])
        else $error("sleep bit left set after wake");
    wake_agree_a: assert property (@(posedge clk_sys) disable iff (rst)  // R11
        (wake_sync_q[2] != wake_sync_q[1]) |=> $stable(wake_q))
        else $error("wake level taken before stages agree");

    ////////////////////////////////////////////////////////////////
    // register read checks
    power_read_a: assert property (@(posedge clk_sys) disable iff (rst)  // R12
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_POWER_CONTROL_REGISTER) |=> rdata == $past(power_control_q))
        else $error("power control read wrong");
    cell5_read_a: assert property (@(posedge clk_sys) disable iff (rst)  // R1 R2
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_CELL5_TRIM)
        |=> rdata == {$past(trim.c5_off_low), $past(trim.c5_gain_low)})
        else $error("cell 5 trim wrong");
    cell6_read_a: assert property (@(posedge clk_sys) disable iff (rst)  // R3 R4
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_CELL6_TRIM)
        |=> rdata == {$past(trim.c6_off_low), $past(trim.c6_gain_low)})
        else $error("cell 6 trim wrong");
    ext_low_a: assert property (@(posedge clk_sys) disable iff (rst)  // R5
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_MSB_LOW)
        |=> rdata == {$past(trim.off_top[0]), $past(trim.gain_top[0]),
                      $past(trim.off_top[1]), $past(trim.gain_top[1]), 4'h0})
        else $error("low extension wrong");
    ext_high_a: assert property (@(posedge clk_sys) disable iff (rst)  // R6
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_MSB_HIGH)
        |=> rdata == {$past(trim.off_top[2]), $past(trim.gain_top[2]),
                      $past(trim.off_top[3]), $past(trim.gain_top[3]),
                      $past(trim.off_top[4]), $past(trim.gain_top[4]),
                      $past(trim.off_top[5]), $past(trim.gain_top[5])})
        else $error("high extension wrong");
    ref_ext_a: assert property (@(posedge clk_sys) disable iff (rst)  // R7
        port_hit(req, req_valid, 1'b0, `CMT_ADDR_REF_MSB)
        |=> rdata == {5'h00, $past(trim.ref_off_b5), $past(trim.ref_off_b4), $past(trim.ref_gain_top)})
        else $error("reference extension wrong");
    trim_no_write_a: assert property (@(posedge clk_sys) disable iff (rst)  // R14
        (req_valid && req.wr) |=> $stable(rdata))
        else $error("write changed read data");
endmodule
`default_nettype wire

// *** dv/cmt_host_model.sv ***
`default_nettype none
module cmt_host_model (
    // clock
    input  wire logic              clk_sys,
    // register port
    output cmt_pkg::cmt_req_t      req,
    output logic                   req_valid,
    input  wire logic [7:0]        rdata,
    // analog status pins
    output logic                   regulator_zero,
    output logic                   wake_pin
);
    import cmt_pkg::*;
    initial begin
        req = '0;
        req_valid = 1'b0;
        regulator_zero = 1'b0;
        wake_pin = 1'b0;
    end
    // one access, held across the taking edge; bus shows inverse once released
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(negedge clk_sys);
        req <= '{wr: wr, addr: addr, wdata: wdata};
        req_valid <= 1'b1;
        @(negedge clk_sys);
        req_valid <= 1'b0;
        req <= '{wr: ~wr, addr: ~addr, wdata: ~wdata};
    endtask
    // host builds the signed reference offset from both extension bits
    function automatic logic [5:0] ref_offset(input logic [7:0] ext, input logic [3:0] low);
        return {ext[2], ext[1], low};
    endfunction
    // wake request pin driven to the given level by the host
    task automatic set_wake(input logic level);
        @(negedge clk_sys);
        wake_pin <= level;
    endtask
    // regulator discharge shown as a digital level
    task automatic set_zero(input logic level);
        @(negedge clk_sys);
        regulator_zero <= level;
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmt_pkg::*;
    logic       clk_sys, rst, req_valid, regulator_zero, wake_pin, shutdown, wake_armed;
    logic [7:0] rdata, power_control;
    cmt_req_t   req;
    cmt_trim_t  trim;
    int         failures, checks_done, cycles;
    cmt_trim_sleep uut (.clk_sys(clk_sys), .rst(rst), .req(req), .req_valid(req_valid), .rdata(rdata),
        .trim(trim), .regulator_zero(regulator_zero), .wake_pin(wake_pin), .shutdown(shutdown),
        .wake_armed(wake_armed), .power_control(power_control));
    cmt_host_model host (.clk_sys(clk_sys), .req(req), .req_valid(req_valid), .rdata(rdata),
        .regulator_zero(regulator_zero), .wake_pin(wake_pin));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // trim reads, then writes that must not stick
    task automatic trim_reads();
        host.access(1'b0, 8'h15, 8'h00);
        check("cell5", rdata, {trim.c5_off_low, trim.c5_gain_low});
        check("cell5 gain", {4'h0, rdata[3:0]}, {4'h0, trim.c5_gain_low});
        host.access(1'b0, 8'h16, 8'h00);
        check("cell6", rdata, {trim.c6_off_low, trim.c6_gain_low});
        check("cell6 gain", {4'h0, rdata[3:0]}, {4'h0, trim.c6_gain_low});
        host.access(1'b0, 8'h17, 8'h00);
        check("msb low", rdata, {trim.off_top[0], trim.gain_top[0], trim.off_top[1], trim.gain_top[1], 4'h0});
        host.access(1'b0, 8'h18, 8'h00);
        check("msb high", rdata, {trim.off_top[2], trim.gain_top[2], trim.off_top[3], trim.gain_top[3],
            trim.off_top[4], trim.gain_top[4], trim.off_top[5], trim.gain_top[5]});
        host.access(1'b1, 8'h1B, 8'hFF);
        host.access(1'b0, 8'h1B, 8'h00);
        check("ref msb", rdata, {5'h00, trim.ref_off_b5, trim.ref_off_b4, trim.ref_gain_top});
        check("ref offset", {2'h0, host.ref_offset(rdata, 4'h0)}, 8'h20);
        host.access(1'b1, 8'h15, 8'h00);
        host.access(1'b0, 8'h15, 8'h00);
        check("cell5 after write", rdata, {trim.c5_off_low, trim.c5_gain_low});
        host.access(1'b0, 8'h33, 8'h00);
        check("unmapped", rdata, 8'h00);
    endtask
    // inhibit held in register, and set in the same write
    task automatic sleep_inhibit();
        host.access(1'b1, 8'h05, 8'h40);
        host.access(1'b0, 8'h05, 8'h00);
        check("inhibit stored", rdata, 8'h40);
        check("control out", power_control, 8'h40);
        host.access(1'b1, 8'h05, 8'h80);
        check("inhibited", {7'h00, shutdown}, 8'h00);
        host.access(1'b1, 8'h05, 8'h00);
        host.access(1'b1, 8'h05, 8'hC0);
        check("inhibited same", {7'h00, shutdown}, 8'h00);
        host.access(1'b1, 8'h05, 8'h00);
    endtask
    // sleep, early wake refused, discharge arms, wake pin releases
    task automatic sleep_wake();
        host.access(1'b1, 8'h05, 8'h80);
        check("asleep", {7'h00, shutdown}, 8'h01);
        check("sleep bit", {7'h00, power_control[7]}, 8'h01);
        host.access(1'b0, 8'h05, 8'h00);
        check("control asleep", rdata, 8'h80);
        host.set_wake(1'b1);
        repeat (12) @(negedge clk_sys);
        check("early wake", {6'h00, shutdown, wake_armed}, 8'h02);
        host.set_wake(1'b0);
        host.set_zero(1'b1);
        for (int i = 0; i < 10 && wake_armed !== 1'b1; i++) @(negedge clk_sys);
        check("armed", {6'h00, shutdown, wake_armed}, 8'h03);
        host.set_wake(1'b1);
        for (int i = 0; i < 10 && shutdown !== 1'b0; i++) @(negedge clk_sys);
        check("woken", {6'h00, shutdown, power_control[7]}, 8'h00);
        check("disarmed", {7'h00, wake_armed}, 8'h00);
        host.set_wake(1'b0);
        host.set_zero(1'b0);
        // let both pin levels pass the stages before the next scenario
        repeat (8) @(negedge clk_sys);
    endtask
    // reset while asleep, then the port works again
    task automatic reset_midrun();
        host.access(1'b1, 8'h05, 8'h81);
        check("asleep again", {7'h00, shutdown}, 8'h01);
        check("control stored", power_control, 8'h81);
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        check("control reset", power_control, 8'h00);
        check("state reset", {6'h00, shutdown, wake_armed}, 8'h00);
        check("rdata reset", rdata, 8'h00);
        host.access(1'b0, 8'h16, 8'h00);
        check("cell6 after reset", rdata, {trim.c6_off_low, trim.c6_gain_low});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ceiling well above the hundred or so cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        trim = '{c5_off_low: 4'hA, c5_gain_low: 4'h3, c6_off_low: 4'h5, c6_gain_low: 4'hC,
            off_top: 6'h29, gain_top: 6'h16, ref_off_b5: 1'b1, ref_off_b4: 1'b0, ref_gain_top: 1'b1};
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        trim_reads();
        sleep_inhibit();
        sleep_wake();
        reset_midrun();
        complete_run();
    end
endmodule
`default_nettype wire
